/* File: sibap_arbiter.sv */
`timescale 1ns/1ns
`include "sibap_regs.svh"
module sibap_arbiter (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Configuration and status
  input wire sibap_pkg::sibap_cfg_t cfg_i,
  input wire logic init_done_i,
  input wire sibap_pkg::sibap_dev_state_t dev_state_i,
  // Internal side of the shared bus
  input wire logic need_bus_i,
  output logic grant_o,
  output logic suspended_o,
  output logic combo_mode_o,
  output logic sys_clk_en_o,
  // Arbitration pins
  input wire logic peer_state_in_i,
  output logic bus_request_out_o,
  // Drive power pin, high means supply off
  output logic drive_power_control_o,
  output logic drive_power_control_oe_o
);

  sibap_pkg::sibap_arb_state_t state;
  sibap_pkg::sibap_arb_state_t next_state;
  logic peer_meta;
  logic peer_sync;
  logic [`SIBAP_ACC_W-1:0] acc;
  logic [`SIBAP_ACC_W-1:0] next_acc;
  logic [`SIBAP_ACC_W-1:0] step;
  logic [`SIBAP_ACC_W:0] acc_sum;
  logic [4:0] en_gap;
  logic combo;
  logic power_on;

  function automatic logic combo_allowed(input sibap_pkg::sibap_cfg_t c);
    combo_allowed = (c.power_source_select == `SIBAP_POWER_SELF) &&
                    (c.clock_rate_select == `SIBAP_CLOCK_COMBO) &&
                    (c.drive_type_bits != `SIBAP_DRIVE_NONE);
  endfunction

  assign combo = combo_allowed(cfg_i);
  assign combo_mode_o = combo;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      peer_meta <= 1'b0;
      peer_sync <= 1'b0;
    end else begin
      peer_meta <= peer_state_in_i;
      peer_sync <= peer_meta;
    end
  end

  // Without combo mode the peer is ignored, like a grounded peer pin
  always_comb begin
    next_state = state;
    case (state)
      sibap_pkg::SIBAP_IDLE: begin
        if (need_bus_i) next_state = sibap_pkg::SIBAP_CHECK;
      end
      sibap_pkg::SIBAP_CHECK: begin
        if (!need_bus_i) next_state = sibap_pkg::SIBAP_IDLE;
        else if (combo && peer_sync) next_state = sibap_pkg::SIBAP_SUSPEND;
        else next_state = sibap_pkg::SIBAP_OWN;
      end
      sibap_pkg::SIBAP_OWN: begin
        if (!need_bus_i) next_state = sibap_pkg::SIBAP_IDLE;
      end
      sibap_pkg::SIBAP_SUSPEND: begin
        if (!need_bus_i) next_state = sibap_pkg::SIBAP_IDLE;
        else if (!peer_sync || !combo) next_state = sibap_pkg::SIBAP_CHECK;
      end
      default: next_state = sibap_pkg::SIBAP_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) state <= sibap_pkg::SIBAP_IDLE;
    else state <= next_state;
  end

  // Request stays up while suspended so the peer sees the pending claim
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) bus_request_out_o <= 1'b0;
    else bus_request_out_o <= (next_state != sibap_pkg::SIBAP_IDLE);
  end

  assign grant_o = (state == sibap_pkg::SIBAP_OWN);
  assign suspended_o = (state == sibap_pkg::SIBAP_SUSPEND);

  // Fractional divider: evenly spaced enables at the selected rate
  assign step = (cfg_i.power_source_select == `SIBAP_POWER_SELF) ?
                `SIBAP_ACC_W'(`SIBAP_SELF_POWER_KHZ) :
                `SIBAP_ACC_W'(`SIBAP_BUS_POWER_KHZ);
  // One spare bit: the self powered step would overflow the accumulator width
  assign acc_sum = {1'b0, acc} + {1'b0, step};
  always_comb begin
    if (acc_sum >= {1'b0, `SIBAP_ACC_W'(`SIBAP_SYS_KHZ)})
      next_acc = `SIBAP_ACC_W'(acc_sum - {1'b0, `SIBAP_ACC_W'(`SIBAP_SYS_KHZ)});
    else
      next_acc = acc_sum[`SIBAP_ACC_W-1:0];
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc <= '0;
      sys_clk_en_o <= 1'b0;
    end else begin
      acc <= next_acc;
      sys_clk_en_o <= (acc_sum >= {1'b0, `SIBAP_ACC_W'(`SIBAP_SYS_KHZ)});
    end
  end

  // Counts quiet enable cycles in bus powered mode for the gap check (a_bus_en_gap)
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_gap <= 5'h00;
    end else if (sys_clk_en_o || !cfg_i.power_source_select) begin
      en_gap <= 5'h00;
    end else if (en_gap != 5'h1f) begin
      en_gap <= en_gap + 5'h01;
    end
  end

  assign power_on = (dev_state_i == sibap_pkg::SIBAP_DEV_CONFIGURED);

  // Pin is pulled up externally, so float means drive off before init
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_power_control_oe_o <= 1'b0;
      drive_power_control_o <= 1'b1;
    end else begin
      drive_power_control_oe_o <= init_done_i;
      drive_power_control_o <= !power_on;
    end
  end

  a_req_follows_state: assert property (@(posedge clock_i) disable iff (!resetn_i)
    bus_request_out_o ==
      (state != sibap_pkg::SIBAP_IDLE))
    else $error("bus request does not match arbitration state");

  a_busy_peer_suspends: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_CHECK && need_bus_i && combo && peer_sync)
      |=> state == sibap_pkg::SIBAP_SUSPEND)
    else $error("busy peer did not cause suspend");

  a_free_peer_grants: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_CHECK && need_bus_i && !(combo && peer_sync))
      |=> grant_o)
    else $error("free bus was not granted");

  a_resume_recheck: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (suspended_o && need_bus_i && !peer_sync)
      |=> state == sibap_pkg::SIBAP_CHECK)
    else $error("suspend did not restart arbitration");

  a_peer_sync_delay: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ##2
      peer_sync == $past(peer_state_in_i, 2))
    else $error("peer state not delayed by two flops");

  a_meta_delay: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ##1
      peer_meta == $past(peer_state_in_i))
    else $error("first peer flop does not follow the pin");

  a_no_combo_no_suspend: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (!combo && state == sibap_pkg::SIBAP_CHECK)
      |=> !suspended_o)
    else $error("suspend outside combo mode");

  a_peer_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (suspended_o && need_bus_i && !combo)
      |=> state == sibap_pkg::SIBAP_CHECK)
    else $error("peer not ignored outside combo mode");

  a_combo_decode: assert property (@(posedge clock_i) disable iff (!resetn_i)
    combo_mode_o == (cfg_i.power_source_select == `SIBAP_POWER_SELF &&
      cfg_i.clock_rate_select == `SIBAP_CLOCK_COMBO && cfg_i.drive_type_bits != 2'h3))
    else $error("combo mode decode wrong");

  a_idle_to_check: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_IDLE && need_bus_i)
      |=> (state == sibap_pkg::SIBAP_CHECK && bus_request_out_o))
    else $error("request did not start an arbitration check");

  a_idle_stays: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_IDLE && !need_bus_i)
      |=> (state == sibap_pkg::SIBAP_IDLE && !bus_request_out_o))
    else $error("idle arbiter raised a request");

  a_idle_never_owns: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state == sibap_pkg::SIBAP_IDLE
      |=> !grant_o)
    else $error("bus taken without a peer check");

  a_own_from_check: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (!grant_o && state != sibap_pkg::SIBAP_CHECK)
      |=> !grant_o)
    else $error("grant not preceded by a check");

  a_check_drop_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_CHECK && !need_bus_i)
      |=> state == sibap_pkg::SIBAP_IDLE)
    else $error("dropped request kept the check state");

  a_own_holds: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (grant_o && need_bus_i)
      |=> grant_o)
    else $error("grant lost while still needed");

  a_own_release: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (grant_o && !need_bus_i)
      |=> (state == sibap_pkg::SIBAP_IDLE && !bus_request_out_o))
    else $error("bus not released after use");

  a_grant_has_req: assert property (@(posedge clock_i) disable iff (!resetn_i)
    grant_o
      |-> bus_request_out_o)
    else $error("bus used without request");

  a_suspend_has_req: assert property (@(posedge clock_i) disable iff (!resetn_i)
    suspended_o
      |-> bus_request_out_o)
    else $error("pending claim dropped while suspended");

  a_suspend_holds: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (suspended_o && need_bus_i && combo && peer_sync)
      |=> suspended_o)
    else $error("left suspend while peer busy");

  a_suspend_drop: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (suspended_o && !need_bus_i)
      |=> (state == sibap_pkg::SIBAP_IDLE && !bus_request_out_o))
    else $error("request kept after need dropped in suspend");

  a_suspend_from_check: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (!suspended_o && state != sibap_pkg::SIBAP_CHECK)
      |=> !suspended_o)
    else $error("suspend entered without a check");

  a_resume_not_own: assert property (@(posedge clock_i) disable iff (!resetn_i)
    suspended_o
      |=> !grant_o)
    else $error("resume skipped the first check");

  a_peer_free_no_susp: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (state == sibap_pkg::SIBAP_CHECK && !peer_sync)
      |=> !suspended_o)
    else $error("suspend with free peer");

  a_power_float_init: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !init_done_i
      |=> !drive_power_control_oe_o)
    else $error("drive power driven before init");

  a_power_drive_init: assert property (@(posedge clock_i) disable iff (!resetn_i)
    init_done_i
      |=> drive_power_control_oe_o)
    else $error("drive power not driven after init");

  a_power_off_states: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (dev_state_i != sibap_pkg::SIBAP_DEV_CONFIGURED)
      |=> drive_power_control_o)
    else $error("drive power on outside configured state");

  a_power_on_conf: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (dev_state_i == sibap_pkg::SIBAP_DEV_CONFIGURED)
      |=> !drive_power_control_o)
    else $error("drive power off in configured state");

  a_clk_en_spacing: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (sys_clk_en_o && cfg_i.power_source_select && $stable(cfg_i))
      |=> (!sys_clk_en_o || !cfg_i.power_source_select) [*8])
    else $error("bus powered clock enable too fast");

  a_bus_en_gap: assert property (@(posedge clock_i) disable iff (!resetn_i)
    cfg_i.power_source_select
      |-> en_gap < 5'h0f)
    else $error("bus powered clock enable too slow");

  a_self_en_dense: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (!sys_clk_en_o && !cfg_i.power_source_select && $stable(cfg_i) && $past(resetn_i))
      |=> sys_clk_en_o)
    else $error("self powered clock enable too slow");

  a_acc_bounded: assert property (@(posedge clock_i) disable iff (!resetn_i)
    1'b1
      |-> acc < `SIBAP_ACC_W'(`SIBAP_SYS_KHZ))
    else $error("clock accumulator out of range");

endmodule // sibap_arbiter

/* File: sibap_peer_model.sv */
`timescale 1ns/1ns
module sibap_peer_model (
  // Clock
  input wire logic clock_i,
  // Bench control
  input wire logic want_i,
  // Arbitration pin
  output logic peer_state_in_o = 1'b0
);
  // High only while the peer wants or holds the shared bus
  always_ff @(posedge clock_i) begin
    peer_state_in_o <= want_i;
  end
endmodule // sibap_peer_model

/* File: sibap_pkg.sv */
package sibap_pkg;
  typedef enum logic [3:0] {
    SIBAP_IDLE = 4'h1,
    SIBAP_CHECK = 4'h2,
    SIBAP_OWN = 4'h4,
    SIBAP_SUSPEND = 4'h8
  } sibap_arb_state_t;

  typedef enum logic [2:0] {
    SIBAP_DEV_DEFAULT = 3'h0,
    SIBAP_DEV_ADDRESSED = 3'h1,
    SIBAP_DEV_CONFIGURED = 3'h2,
    SIBAP_DEV_SUSPENDED = 3'h3
  } sibap_dev_state_t;

  typedef struct packed {
    logic power_source_select;
    logic clock_rate_select;
    logic [1:0] drive_type_bits;
  } sibap_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sibap_pin_t;
endpackage

/* File: sibap_regs.svh */
`ifndef SIBAP_REGS_SVH
`define SIBAP_REGS_SVH
// Configuration encodings
`define SIBAP_POWER_SELF 1'b0
`define SIBAP_CLOCK_COMBO 1'b1
`define SIBAP_DRIVE_ATA 2'h2
`define SIBAP_DRIVE_PACKET 2'h1
`define SIBAP_DRIVE_AUTO 2'h0
`define SIBAP_DRIVE_NONE 2'h3
// Clock rates in kHz
`define SIBAP_SYS_KHZ 100000
`define SIBAP_BUS_POWER_KHZ 7500
`define SIBAP_SELF_POWER_KHZ 60000
// Phase accumulator width in bits, modulus is SIBAP_SYS_KHZ
`define SIBAP_ACC_W 17
`endif

/* File: tb.sv */
`timescale 1ns/1ns
`include "sibap_regs.svh"
module tb;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  sibap_pkg::sibap_cfg_t cfg = 4'h6;
  logic init_done = 1'b0;
  sibap_pkg::sibap_dev_state_t dev_state = sibap_pkg::SIBAP_DEV_DEFAULT;
  logic need_bus = 1'b0;
  logic peer_want = 1'b0;
  logic peer_state, grant, susp, combo, clk_en, bus_req, drive_power_control, dpc_oe;
  int num_errors = 0;
  int total_checks = 0;
  always #5 clock_i = ~clock_i;
  sibap_peer_model u_sibap_peer_model (.clock_i(clock_i), .want_i(peer_want),
    .peer_state_in_o(peer_state));
  sibap_arbiter u_sibap_arbiter (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_i(cfg),
    .init_done_i(init_done), .dev_state_i(dev_state), .need_bus_i(need_bus),
    .grant_o(grant), .suspended_o(susp), .combo_mode_o(combo), .sys_clk_en_o(clk_en),
    .peer_state_in_i(peer_state), .bus_request_out_o(bus_req),
    .drive_power_control_o(drive_power_control), .drive_power_control_oe_o(dpc_oe));
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Request the bus; grant expected within lim cycles of the request
  task automatic use_bus(input int lim);
    int n;
    need_bus = 1'b1;
    tick(1);
    check(bus_req, 1'b1);
    for (n = 1; n < lim && grant !== 1'b1; n++) tick(1);
    if (grant !== 1'b1) begin
      check(grant, 1'b1);
      wrap_up();
    end
    check(susp, 1'b0);
    need_bus = 1'b0;
    tick(2);
    check({grant, bus_req}, 2'h0);
  endtask
  task automatic test_power;
    check(dpc_oe, 1'b0);
    init_done = 1'b1;
    tick(1);
    check(dpc_oe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      dev_state = sibap_pkg::sibap_dev_state_t'(i);
      tick(2);
      check(drive_power_control, i != 2);
    end
    $display("test power done");
  endtask
  task automatic test_arb;
    for (int i = 0; i < 6; i++) begin
      cfg = (i < 4) ? {2'b01, 2'(i)} : {i == 4, 3'h0};
      tick(1);
      check(combo, i < 3);
    end
    cfg = 4'h6;
    use_bus(2);
    peer_want = 1'b1;
    tick(4);
    need_bus = 1'b1;
    tick(4);
    check({susp, grant, bus_req}, 3'h5);
    peer_want = 1'b0;
    use_bus(8);
    cfg = 4'he;
    peer_want = 1'b1;
    tick(4);
    use_bus(2);
    peer_want = 1'b0;
    $display("test arbitration done");
  endtask
  task automatic test_clk;
    int cnt;
    int want;
    for (int p = 1; p >= 0; p--) begin
      cfg.power_source_select = p[0];
      tick(2);
      cnt = 0;
      repeat (400) begin
        tick(1);
        cnt += int'(clk_en === 1'b1);
      end
      want = p ? 400 * `SIBAP_BUS_POWER_KHZ : 400 * `SIBAP_SELF_POWER_KHZ;
      check(9'(cnt), 9'(want / `SIBAP_SYS_KHZ));
    end
    $display("test clock done");
  endtask
  initial begin
    tick(12);
    resetn_i = 1'b1;
    tick(1);
    test_power();
    test_arb();
    test_clk();
    wrap_up();
  end
endmodule // tb
